//--- dv/tb_tlb_config_and_management.sv
`timescale 1ns/10ps
`define CHECK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb_tlb_config_and_management;
  logic core_clk, nrst, op_valid, user_mode, spr_rd, spr_wr, miss_event, miss_space, op_done, priv_exc;
  tlbcm_pkg::tlbcm_op_t op_code;
  logic [4:0] ra_index;
  logic [31:0] ra_value, rb_value, spr_wdata, miss_ea, spr_rdata;
  logic [9:0] spr_num;
  logic [7:0] current_process_id;
  int miscompares = 0;
  int total_checks = 0;
  logic done, exc;
  logic [31:0] d, r1, r2, r3;
  logic [31:0] a1 [3] = '{32'h8005_1000, 32'hC000_0000, 32'h8009_0000};
  logic [31:0] a2 [3] = '{32'h1111_1400, 32'h3333_3000, 32'h5555_5800};
  logic [31:0] a3 [3] = '{32'h2222_2555, 32'h4444_4AAA, 32'h6666_6033};
  logic [9:0] asr_nums [6] = '{10'h270, 10'h271, 10'h272, 10'h273, 10'h274, 10'h276};
  logic [31:0] mea = 32'hABCD_E123;

  tlbcm_top uut (.core_clk(core_clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code), .user_mode(user_mode),
    .ra_index(ra_index), .ra_value(ra_value), .rb_value(rb_value), .spr_rd(spr_rd), .spr_wr(spr_wr),
    .spr_num(spr_num), .spr_wdata(spr_wdata), .miss_event(miss_event), .miss_ea(miss_ea), .miss_space(miss_space),
    .current_process_id(current_process_id), .spr_rdata(spr_rdata), .op_done(op_done), .priv_exc(priv_exc));

  tlbcm_core_model core (.core_clk(core_clk), .op_valid(op_valid), .op_code(op_code), .user_mode(user_mode),
    .ra_index(ra_index), .ra_value(ra_value), .rb_value(rb_value), .spr_rd(spr_rd), .spr_wr(spr_wr),
    .spr_num(spr_num), .spr_wdata(spr_wdata), .miss_event(miss_event), .miss_ea(miss_ea), .miss_space(miss_space),
    .current_process_id(current_process_id), .spr_rdata(spr_rdata), .op_done(op_done), .priv_exc(priv_exc));

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task end_sim;
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task op(input tlbcm_pkg::tlbcm_op_t c, input logic u, input logic [4:0] ri, input logic [31:0] ra,
    input logic [31:0] rb);
    core.run_op(c, u, ri, ra, rb, done, exc);
  endtask

  task sel_entry(input int k);
    core.spr_write(tlbcm_pkg::SPR_ASR0, 32'h1000_0000 | 32'(k << 16));
  endtask

  task read_entry(input int k);
    sel_entry(k);
    op(tlbcm_pkg::OP_READ, 1'b0, 5'h00, 32'h0, 32'h0);
    core.spr_read(tlbcm_pkg::SPR_ASR1, r1);
    core.spr_read(tlbcm_pkg::SPR_ASR2, r2);
    core.spr_read(tlbcm_pkg::SPR_ASR3, r3);
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    nrst = 1'b0;
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    // Configuration registers ignore writes
    core.spr_write(tlbcm_pkg::SPR_NULL_CFG, 32'hFFFF_FFFF);
    core.spr_read(tlbcm_pkg::SPR_NULL_CFG, d);
    `CHECK(d, 32'h0000_0000);
    core.spr_write(tlbcm_pkg::SPR_ASSOCIATIVITY_FIELD_CFG, 32'h0000_0000);
    core.spr_read(tlbcm_pkg::SPR_ASSOCIATIVITY_FIELD_CFG, d);
    `CHECK(d[31:24], 8'h10);
    `CHECK(d[11:0], 12'h010);
    `CHECK(d[23:20], 4'h0);
    `CHECK(d[19:16], 4'hB);
    `CHECK(d[15:13], 3'h7);
    `CHECK(d[12], 1'b0);
    $display("Test config done");
    for (int i = 0; i < 6; i++)
    begin
      core.spr_write(asr_nums[i], 32'hA5C3_0F00 ^ 32'(i));
      core.spr_read(asr_nums[i], d);
      `CHECK(d, 32'hA5C3_0F00 ^ 32'(i));
    end
    $display("Test assist registers done");
    for (int k = 0; k < 3; k++)
    begin
      core.spr_write(tlbcm_pkg::SPR_ASR1, a1[k]);
      core.spr_write(tlbcm_pkg::SPR_ASR2, a2[k]);
      core.spr_write(tlbcm_pkg::SPR_ASR3, a3[k]);
      sel_entry(k);
      op(tlbcm_pkg::OP_WRITE, 1'b0, 5'h00, 32'h0, 32'h0);
      `CHECK(done, 1'b1);
      // Read straight after the write, one idle cycle between the two operations
      op(tlbcm_pkg::OP_READ, 1'b0, 5'h00, 32'h0, 32'h0);
      core.spr_read(tlbcm_pkg::SPR_ASR2, d);
      `CHECK(d, a2[k]);
    end
    for (int k = 0; k < 3; k++)
    begin
      read_entry(k);
      `CHECK({r1, r2, r3}, {a1[k], a2[k], a3[k]});
    end
    $display("Test write and read entry done");
    core.spr_write(tlbcm_pkg::SPR_ASR1, 32'h8077_0000);
    sel_entry(2);
    for (int i = 0; i < 5; i++)
    begin
      op(tlbcm_pkg::tlbcm_op_t'(3'(i)), 1'b1, 5'h03, 32'h5555_0000, 32'h0000_580C);
      `CHECK({done, exc}, 2'b01);
    end
    core.spr_read(tlbcm_pkg::SPR_ASR1, d);
    `CHECK(d, 32'h8077_0000);
    read_entry(2);
    `CHECK(r1, a1[2]);
    op(tlbcm_pkg::OP_SYNC, 1'b0, 5'h00, 32'h0, 32'h0);
    `CHECK({done, exc}, 2'b10);
    core.spr_read(tlbcm_pkg::SPR_ASR1, d);
    `CHECK(d, a1[2]);
    $display("Test privilege done");
    core.spr_write(tlbcm_pkg::SPR_ASR_SEARCH, 32'h0009_0000);
    op(tlbcm_pkg::OP_SEARCH, 1'b0, 5'h03, 32'h5555_0000, 32'h0000_5ABC);
    core.spr_read(tlbcm_pkg::SPR_ASR0, d);
    `CHECK({d[29:28], d[19:16]}, 6'h12);
    core.spr_read(tlbcm_pkg::SPR_ASR1, d);
    `CHECK(d, a1[2]);
    core.spr_read(tlbcm_pkg::SPR_ASR3, d);
    `CHECK(d, a3[2]);
    op(tlbcm_pkg::OP_SEARCH, 1'b0, 5'h00, 32'h5555_0000, 32'h0000_5ABC);
    core.spr_read(tlbcm_pkg::SPR_ASR1, d);
    `CHECK(d[31], 1'b0);
    core.spr_read(tlbcm_pkg::SPR_ASR2, d);
    `CHECK(d[31:10], 22'h000016);
    core.spr_read(tlbcm_pkg::SPR_ASR3, d);
    `CHECK(d, 32'h0000_0000);
    core.spr_write(tlbcm_pkg::SPR_ASR_SEARCH, 32'h0005_0000);
    op(tlbcm_pkg::OP_SEARCH, 1'b0, 5'h03, 32'h5555_0000, 32'h0000_5ABC);
    core.spr_read(tlbcm_pkg::SPR_ASR1, d);
    `CHECK(d[31], 1'b0);
    core.spr_write(tlbcm_pkg::SPR_ASR_SEARCH, 32'h0005_0001);
    op(tlbcm_pkg::OP_SEARCH, 1'b0, 5'h00, 32'h0, 32'h1111_1555);
    core.spr_read(tlbcm_pkg::SPR_ASR0, d);
    `CHECK({d[29:28], d[19:16]}, 6'h10);
    $display("Test search done");
    op(tlbcm_pkg::OP_INVAL, 1'b0, 5'h00, 32'h0, 32'h1111_17FB);
    read_entry(0);
    `CHECK(r1[31], 1'b0);
    op(tlbcm_pkg::OP_INVAL, 1'b0, 5'h00, 32'h0, 32'h3333_3008);
    read_entry(1);
    `CHECK(r1, a1[1]);
    op(tlbcm_pkg::OP_INVAL, 1'b0, 5'h00, 32'h0, 32'h0000_000C);
    read_entry(2);
    `CHECK(r1[31], 1'b0);
    read_entry(1);
    `CHECK(r1, a1[1]);
    $display("Test invalidate done");
    core.spr_write(tlbcm_pkg::SPR_ASR4, 32'h1000_0185);
    core.spr_write(tlbcm_pkg::SPR_ASR0, 32'h0000_0007);
    core.raise_miss(mea, 1'b1, 8'h42);
    core.spr_read(tlbcm_pkg::SPR_ASR0, d);
    `CHECK({d[29:28], d[19:16]}, 6'h17);
    core.spr_read(tlbcm_pkg::SPR_ASR1, d);
    `CHECK({d[31], d[23:16], d[12], d[11:7]}, {1'b1, 8'h42, 1'b1, 5'h03});
    core.spr_read(tlbcm_pkg::SPR_ASR2, d);
    `CHECK({d[31:10], d[4:0]}, {mea[31:10], 5'h05});
    core.spr_read(tlbcm_pkg::SPR_ASR3, d);
    `CHECK(d, 32'h0000_0000);
    $display("Test miss update done");
    end_sim();
  end
endmodule

//--- dv/tlbcm_core_model.sv
`timescale 1ns/10ps
module tlbcm_core_model (
  input wire logic core_clk,
  output logic op_valid,
  output tlbcm_pkg::tlbcm_op_t op_code,
  output logic user_mode,
  output logic [4:0] ra_index,
  output logic [31:0] ra_value,
  output logic [31:0] rb_value,
  output logic spr_rd,
  output logic spr_wr,
  output logic [9:0] spr_num,
  output logic [31:0] spr_wdata,
  output logic miss_event,
  output logic [31:0] miss_ea,
  output logic miss_space,
  output logic [7:0] current_process_id,
  input wire logic [31:0] spr_rdata,
  input wire logic op_done,
  input wire logic priv_exc
);
  initial
  begin
    op_valid = 1'b0;
    op_code = tlbcm_pkg::OP_SYNC;
    user_mode = 1'b0;
    ra_index = 5'h00;
    ra_value = 32'h0000_0000;
    rb_value = 32'h0000_0000;
    spr_rd = 1'b0;
    spr_wr = 1'b0;
    spr_num = 10'h000;
    spr_wdata = 32'h0000_0000;
    miss_event = 1'b0;
    miss_ea = 32'h0000_0000;
    miss_space = 1'b0;
    current_process_id = 8'h00;
  end

  // Released data lines show the inverse so stale values are never mistaken for live ones
  task spr_write(input logic [9:0] num, input logic [31:0] data);
    @(negedge core_clk);
    spr_wr = 1'b1;
    spr_num = num;
    spr_wdata = data;
    @(negedge core_clk);
    spr_wr = 1'b0;
    spr_wdata = ~data;
  endtask

  task spr_read(input logic [9:0] num, output logic [31:0] data);
    @(negedge core_clk);
    spr_rd = 1'b1;
    spr_num = num;
    @(negedge core_clk);
    data = spr_rdata;
    spr_rd = 1'b0;
  endtask

  task run_op(input tlbcm_pkg::tlbcm_op_t code, input logic user, input logic [4:0] ri, input logic [31:0] ra,
    input logic [31:0] rb, output logic done, output logic exc);
    @(negedge core_clk);
    op_valid = 1'b1;
    op_code = code;
    user_mode = user;
    ra_index = ri;
    ra_value = ra;
    rb_value = rb;
    @(negedge core_clk);
    done = op_done;
    exc = priv_exc;
    op_valid = 1'b0;
    ra_value = ~ra;
    rb_value = ~rb;
  endtask

  task raise_miss(input logic [31:0] ea, input logic space, input logic [7:0] pid);
    @(negedge core_clk);
    miss_event = 1'b1;
    miss_ea = ea;
    miss_space = space;
    current_process_id = pid;
    @(negedge core_clk);
    miss_event = 1'b0;
    miss_ea = ~ea;
  endtask
endmodule

//--- rtl/tlbcm_pkg.sv
package tlbcm_pkg;
  localparam int ENTRIES = 16;
  localparam int IDX_W = 4;
  localparam int EPN_W = 22;
  localparam int EPN_LSB = 10;
  localparam int MAX_SIZE_CODE = 22;

  // Special register numbers
  localparam logic [9:0] SPR_NULL_CFG = 10'h2B0;
  localparam logic [9:0] SPR_ASSOCIATIVITY_FIELD_CFG = 10'h2B1;
  localparam logic [9:0] SPR_ASR0 = 10'h270;
  localparam logic [9:0] SPR_ASR1 = 10'h271;
  localparam logic [9:0] SPR_ASR2 = 10'h272;
  localparam logic [9:0] SPR_ASR3 = 10'h273;
  localparam logic [9:0] SPR_ASR4 = 10'h274;
  localparam logic [9:0] SPR_ASR_SEARCH = 10'h276;

  // Configuration register contents, LSB numbering
  localparam logic [31:0] NULL_CFG_VALUE = 32'h0000_0000;
  localparam logic [7:0] ASSOCIATIVITY_FIELD = 8'h10;
  localparam logic [3:0] MIN_PAGE_SIZE_FIELD = 4'h0;
  localparam logic [3:0] MAX_PAGE_SIZE_FIELD = 4'hB;
  localparam logic [0:0] INVALIDATION_PROTECT = 1'h1;
  localparam logic [0:0] ALL_SIZES_AVAILABLE = 1'h1;
  localparam logic [0:0] ODD_POWER_SIZES_FLAG = 1'h1;
  localparam logic [0:0] CFG_RESERVED_BIT = 1'h0;
  localparam logic [11:0] ENTRY_COUNT_FIELD = 12'h010;
  localparam logic [31:0] ASSOCIATIVITY_FIELD_CFG_VALUE = {ASSOCIATIVITY_FIELD, MIN_PAGE_SIZE_FIELD, MAX_PAGE_SIZE_FIELD,
    INVALIDATION_PROTECT, ALL_SIZES_AVAILABLE, ODD_POWER_SIZES_FLAG, CFG_RESERVED_BIT, ENTRY_COUNT_FIELD};

  // Assist register field positions
  localparam int A0_SEL_LSB = 28;
  localparam int A0_ENTRY_SELECT_LSB = 16;
  localparam int A0_NV_LSB = 0;
  localparam int A1_VALID = 31;
  localparam int A1_INVALIDATION_PROTECT = 30;
  localparam int A1_PID_LSB = 16;
  localparam int A1_TS = 12;
  localparam int A1_SIZE_LSB = 7;
  localparam int A2_EPN_LSB = 10;
  localparam int A2_ATTR_LSB = 0;
  localparam int A3_RPN_LSB = 10;
  localparam int A3_PERM_LSB = 0;
  localparam int S_PID_LSB = 16;
  localparam int S_SAS = 0;
  localparam logic [1:0] SEL_ASSOCIATIVITY_FIELD = 2'h1;
  localparam logic [31:0] ASR_RESET = 32'h0000_0000;

  // Invalidate address control bits, LSB numbering
  localparam int INV_SEL_BIT = 3;
  localparam int INVALIDATE_EVERYTHING_BIT = 2;

  typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_SEARCH, OP_INVAL, OP_SYNC} tlbcm_op_t;
endpackage

//--- rtl/tlbcm_top.sv
`timescale 1ns/10ps
// Summary of operation
// RULE_01 - Null array config register at 688 always reads all zeros.
// RULE_02 - Associative array config register at 689 is read-only; bit 12 reads zero.
// RULE_03 - Associativity field and entry count field both read 0x10, sixteen entries.
// RULE_04 - Minimum page size reads 0x0 and maximum page size reads 0xB.
// RULE_05 - Protect, all-sizes and odd-power-size capability bits each read one.
// RULE_06 - Read entry copies the selected entry into assist registers 1 to 3.
// RULE_07 - Write entry stores assist registers 1 to 3 into the selected entry.
// RULE_08 - Translation miss loads assist registers with address, defaults and replacement entry.
// RULE_09 - Software places page number and permissions before issuing write entry.
// RULE_10 - Search address is sum of both sources if first index nonzero, else second.
// RULE_11 - Search compares space bit, process ID, address; writes hit or miss results.
// RULE_12 - Invalidate by address matches page number only, ignoring space and process ID.
// RULE_13 - Software sets the array-select bit of an invalidate address to one.
// RULE_14 - Invalidate-all bit clears every entry whose protect bit is clear.
// RULE_15 - Other invalidate address control bits are ignored.
// RULE_16 - All buffer management operations require privileged mode.
// RULE_17 - Synchronize does nothing beyond the privilege check.
// RULE_18 - Storage interrupt handler loads search fields then issues a search.
// RULE_19 - Assist registers are readable and writable through special register moves.
// RULE_20 - Protected entries survive every invalidate, including invalidate-all.
// RULE_21 - Search sets assist register 1 valid bit on hit, clears it on miss.
// RULE_22 - User-mode management operation raises exception and changes no state.
module tlbcm_top #(
  parameter int ENTRIES = tlbcm_pkg::ENTRIES,
  parameter int IDX_W = tlbcm_pkg::IDX_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic op_valid,
  input wire tlbcm_pkg::tlbcm_op_t op_code,
  input wire logic user_mode,
  input wire logic [4:0] ra_index,
  input wire logic [31:0] ra_value,
  input wire logic [31:0] rb_value,
  input wire logic spr_rd,
  input wire logic spr_wr,
  input wire logic [9:0] spr_num,
  input wire logic [31:0] spr_wdata,
  input wire logic miss_event,
  input wire logic [31:0] miss_ea,
  input wire logic miss_space,
  input wire logic [7:0] current_process_id,
  output logic [31:0] spr_rdata,
  output logic op_done,
  output logic priv_exc
);
  logic [31:0] asr0, asr1, asr2, asr3, asr4, asr_search;
  logic ent_valid [ENTRIES];
  logic ent_invalidation_protect [ENTRIES];
  logic ent_space [ENTRIES];
  logic [7:0] ent_pid [ENTRIES];
  logic [4:0] ent_size [ENTRIES];
  logic [21:0] ent_epn [ENTRIES];
  logic [4:0] ent_attr [ENTRIES];
  logic [21:0] ent_rpn [ENTRIES];
  logic [9:0] ent_perm [ENTRIES];
  logic [ENTRIES-1:0] srch_match, inv_match;
  logic [31:0] eff_addr;
  logic op_ok;
  logic sel_associativity_field;
  logic [IDX_W-1:0] entry_select, hit_idx, view_idx;
  logic hit_any;
  logic [31:0] view1, view2, view3;
  logic [7:0] search_process_id;
  logic search_space_bit;

  // Page-number bits compared for a page size; larger pages compare fewer bits
  function automatic logic [21:0] page_mask(input logic [4:0] size);
    logic [21:0] m;
    m = '0;
    for (int j = 0; j < tlbcm_pkg::EPN_W; j++)
    begin
      m[j] = (j >= int'(size)) && (int'(size) < tlbcm_pkg::MAX_SIZE_CODE);
    end
    return m;
  endfunction

  assign eff_addr = (ra_index != 5'h00) ? ra_value + rb_value : rb_value; // [RULE_10]
  assign op_ok = op_valid && !user_mode; // [RULE_16] [RULE_22]
  assign entry_select = asr0[tlbcm_pkg::A0_ENTRY_SELECT_LSB +: IDX_W];
  assign sel_associativity_field = asr0[tlbcm_pkg::A0_SEL_LSB +: 2] == tlbcm_pkg::SEL_ASSOCIATIVITY_FIELD;
  assign search_process_id = asr_search[tlbcm_pkg::S_PID_LSB +: 8];
  assign search_space_bit = asr_search[tlbcm_pkg::S_SAS];

  generate
    for (genvar g = 0; g < ENTRIES; g++)
    begin : g_match
      logic epn_eq;
      assign epn_eq = ((ent_epn[g] ^ eff_addr[31:tlbcm_pkg::EPN_LSB]) & page_mask(ent_size[g])) == 22'h0;
      assign srch_match[g] = ent_valid[g] && epn_eq && (ent_space[g] == search_space_bit) &&
        ((ent_pid[g] == search_process_id) || (ent_pid[g] == 8'h00)); // [RULE_11]
      // Address bits 0-1 and 4-9 take no part in the match
      assign inv_match[g] = ent_valid[g] && !ent_invalidation_protect[g] && eff_addr[tlbcm_pkg::INV_SEL_BIT] &&
        (eff_addr[tlbcm_pkg::INVALIDATE_EVERYTHING_BIT] || epn_eq); // [RULE_12] [RULE_14] [RULE_15] [RULE_20]
    end
  endgenerate

  // Lowest matching entry wins; multiple hits are a software error
  always_comb
  begin
    hit_any = 1'b0;
    hit_idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (srch_match[i])
      begin
        hit_any = 1'b1;
        hit_idx = IDX_W'(i);
      end
    end
  end

  // Entry image as seen through assist registers 1 to 3
  always_comb
  begin
    view_idx = (op_code == tlbcm_pkg::OP_SEARCH) ? hit_idx : entry_select;
    view1 = '0;
    view2 = '0;
    view3 = '0;
    view1[tlbcm_pkg::A1_VALID] = ent_valid[view_idx];
    view1[tlbcm_pkg::A1_INVALIDATION_PROTECT] = ent_invalidation_protect[view_idx];
    view1[tlbcm_pkg::A1_PID_LSB +: 8] = ent_pid[view_idx];
    view1[tlbcm_pkg::A1_TS] = ent_space[view_idx];
    view1[tlbcm_pkg::A1_SIZE_LSB +: 5] = ent_size[view_idx];
    view2[tlbcm_pkg::A2_EPN_LSB +: 22] = ent_epn[view_idx];
    view2[tlbcm_pkg::A2_ATTR_LSB +: 5] = ent_attr[view_idx];
    view3[tlbcm_pkg::A3_RPN_LSB +: 22] = ent_rpn[view_idx];
    view3[tlbcm_pkg::A3_PERM_LSB +: 10] = ent_perm[view_idx];
  end

  // Buffer entries
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        ent_valid[i] <= 1'b0;
        ent_invalidation_protect[i] <= 1'b0;
        ent_space[i] <= 1'b0;
        ent_pid[i] <= 8'h00;
        ent_size[i] <= 5'h00;
        ent_epn[i] <= 22'h0;
        ent_attr[i] <= 5'h00;
        ent_rpn[i] <= 22'h0;
        ent_perm[i] <= 10'h000;
      end
    end
    else if (op_ok)
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        if (op_code == tlbcm_pkg::OP_WRITE && sel_associativity_field && entry_select == IDX_W'(i)) // [RULE_07]
        begin
          ent_valid[i] <= asr1[tlbcm_pkg::A1_VALID];
          ent_invalidation_protect[i] <= asr1[tlbcm_pkg::A1_INVALIDATION_PROTECT];
          ent_pid[i] <= asr1[tlbcm_pkg::A1_PID_LSB +: 8];
          ent_space[i] <= asr1[tlbcm_pkg::A1_TS];
          ent_size[i] <= asr1[tlbcm_pkg::A1_SIZE_LSB +: 5];
          ent_epn[i] <= asr2[tlbcm_pkg::A2_EPN_LSB +: 22];
          ent_attr[i] <= asr2[tlbcm_pkg::A2_ATTR_LSB +: 5];
          ent_rpn[i] <= asr3[tlbcm_pkg::A3_RPN_LSB +: 22];
          ent_perm[i] <= asr3[tlbcm_pkg::A3_PERM_LSB +: 10];
        end
        else if (op_code == tlbcm_pkg::OP_INVAL && inv_match[i]) // [RULE_14] [RULE_20]
        begin
          ent_valid[i] <= 1'b0;
        end
      end
    end
  end

  // Assist registers: miss update beats a read or search operation, which beats a register write
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      asr0 <= tlbcm_pkg::ASR_RESET;
      asr1 <= tlbcm_pkg::ASR_RESET;
      asr2 <= tlbcm_pkg::ASR_RESET;
      asr3 <= tlbcm_pkg::ASR_RESET;
      asr4 <= tlbcm_pkg::ASR_RESET;
      asr_search <= tlbcm_pkg::ASR_RESET;
    end
    else if (miss_event)
    begin
      asr0[tlbcm_pkg::A0_SEL_LSB +: 2] <= asr4[tlbcm_pkg::A0_SEL_LSB +: 2]; // [RULE_08]
      asr0[tlbcm_pkg::A0_ENTRY_SELECT_LSB +: IDX_W] <= asr0[tlbcm_pkg::A0_NV_LSB +: IDX_W]; // [RULE_08]
      asr1 <= '0;
      asr1[tlbcm_pkg::A1_VALID] <= 1'b1;
      asr1[tlbcm_pkg::A1_PID_LSB +: 8] <= current_process_id;
      asr1[tlbcm_pkg::A1_TS] <= miss_space;
      asr1[tlbcm_pkg::A1_SIZE_LSB +: 5] <= asr4[tlbcm_pkg::A1_SIZE_LSB +: 5];
      asr2 <= '0;
      asr2[tlbcm_pkg::A2_EPN_LSB +: 22] <= miss_ea[31:tlbcm_pkg::EPN_LSB];
      asr2[tlbcm_pkg::A2_ATTR_LSB +: 5] <= asr4[tlbcm_pkg::A2_ATTR_LSB +: 5];
      asr3 <= '0;
    end
    else if (op_ok && op_code == tlbcm_pkg::OP_READ)
    begin
      asr1 <= sel_associativity_field ? view1 : '0; // [RULE_06]
      asr2 <= sel_associativity_field ? view2 : '0;
      asr3 <= sel_associativity_field ? view3 : '0;
    end
    else if (op_ok && op_code == tlbcm_pkg::OP_SEARCH)
    begin
      if (hit_any)
      begin
        asr0[tlbcm_pkg::A0_SEL_LSB +: 2] <= tlbcm_pkg::SEL_ASSOCIATIVITY_FIELD; // [RULE_11]
        asr0[tlbcm_pkg::A0_ENTRY_SELECT_LSB +: IDX_W] <= hit_idx;
        asr1 <= view1; // [RULE_21]
        asr2 <= view2;
        asr3 <= view3;
      end
      else
      begin
        asr0[tlbcm_pkg::A0_SEL_LSB +: 2] <= asr4[tlbcm_pkg::A0_SEL_LSB +: 2];
        asr0[tlbcm_pkg::A0_ENTRY_SELECT_LSB +: IDX_W] <= asr0[tlbcm_pkg::A0_NV_LSB +: IDX_W];
        asr1 <= '0; // [RULE_21]
        asr1[tlbcm_pkg::A1_PID_LSB +: 8] <= search_process_id;
        asr1[tlbcm_pkg::A1_TS] <= search_space_bit;
        asr1[tlbcm_pkg::A1_SIZE_LSB +: 5] <= asr4[tlbcm_pkg::A1_SIZE_LSB +: 5];
        asr2 <= '0;
        asr2[tlbcm_pkg::A2_EPN_LSB +: 22] <= eff_addr[31:tlbcm_pkg::EPN_LSB];
        asr2[tlbcm_pkg::A2_ATTR_LSB +: 5] <= asr4[tlbcm_pkg::A2_ATTR_LSB +: 5];
        asr3 <= '0;
      end
    end
    else if (spr_wr)
    begin
      unique case (spr_num) // [RULE_19]
        tlbcm_pkg::SPR_ASR0: asr0 <= spr_wdata;
        tlbcm_pkg::SPR_ASR1: asr1 <= spr_wdata;
        tlbcm_pkg::SPR_ASR2: asr2 <= spr_wdata;
        tlbcm_pkg::SPR_ASR3: asr3 <= spr_wdata;
        tlbcm_pkg::SPR_ASR4: asr4 <= spr_wdata;
        tlbcm_pkg::SPR_ASR_SEARCH: asr_search <= spr_wdata;
        default: asr0 <= asr0;
      endcase
    end
  end

  // Register read data, one cycle after the read strobe
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      spr_rdata <= 32'h0000_0000;
    end
    else if (spr_rd)
    begin
      unique case (spr_num)
        tlbcm_pkg::SPR_NULL_CFG: spr_rdata <= tlbcm_pkg::NULL_CFG_VALUE; // [RULE_01]
        tlbcm_pkg::SPR_ASSOCIATIVITY_FIELD_CFG: spr_rdata <= tlbcm_pkg::ASSOCIATIVITY_FIELD_CFG_VALUE; // [RULE_02] [RULE_03] [RULE_04] [RULE_05]
        tlbcm_pkg::SPR_ASR0: spr_rdata <= asr0; // [RULE_19]
        tlbcm_pkg::SPR_ASR1: spr_rdata <= asr1;
        tlbcm_pkg::SPR_ASR2: spr_rdata <= asr2;
        tlbcm_pkg::SPR_ASR3: spr_rdata <= asr3;
        tlbcm_pkg::SPR_ASR4: spr_rdata <= asr4;
        tlbcm_pkg::SPR_ASR_SEARCH: spr_rdata <= asr_search;
        default: spr_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Completion and privilege fault pulses
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      op_done <= 1'b0;
      priv_exc <= 1'b0;
    end
    else
    begin
      op_done <= op_ok; // [RULE_17]
      priv_exc <= op_valid && user_mode; // [RULE_22]
    end
  end

  sequence s_user_op;
    op_valid && user_mode && !miss_event && !spr_wr;
  endsequence

  sequence s_write_then_read;
    op_ok && op_code == tlbcm_pkg::OP_WRITE && sel_associativity_field && !miss_event && !spr_wr
      ##1 !op_valid && !spr_wr && !miss_event && $stable(entry_select)
      ##1 op_ok && op_code == tlbcm_pkg::OP_READ && !miss_event && $stable(entry_select) && sel_associativity_field;
  endsequence

  property p_null_cfg;
    @(posedge core_clk) disable iff (!nrst)
    spr_rd && spr_num == tlbcm_pkg::SPR_NULL_CFG |=> spr_rdata == 32'h0000_0000;
  endproperty
  a_null_cfg: assert property (p_null_cfg) else $error("null array config not zero"); // [RULE_01]

  property p_associativity_field_cfg;
    @(posedge core_clk) disable iff (!nrst)
    spr_rd && spr_num == tlbcm_pkg::SPR_ASSOCIATIVITY_FIELD_CFG |=> spr_rdata == 32'h100B_E010 && spr_rdata[12] == 1'b0;
  endproperty
  a_associativity_field_cfg: assert property (p_associativity_field_cfg) else $error("associativity_field array config wrong"); // [RULE_03]

  property p_user_blocked;
    @(posedge core_clk) disable iff (!nrst)
    s_user_op |=> priv_exc && !op_done && $stable(asr1) && $stable(asr0) && ent_valid[0] == $past(ent_valid[0]);
  endproperty
  a_user_blocked: assert property (p_user_blocked) else $error("user mode operation not blocked"); // [RULE_22]

  property p_sync_noop;
    @(posedge core_clk) disable iff (!nrst)
    op_ok && op_code == tlbcm_pkg::OP_SYNC && !miss_event && !spr_wr
      |=> op_done && $stable(asr0) && $stable(asr1) && $stable(asr2) && $stable(asr3);
  endproperty
  a_sync_noop: assert property (p_sync_noop) else $error("synchronize changed state"); // [RULE_17]

  property p_search_flag;
    @(posedge core_clk) disable iff (!nrst)
    op_ok && op_code == tlbcm_pkg::OP_SEARCH && !miss_event |=> asr1[tlbcm_pkg::A1_VALID] == $past(hit_any);
  endproperty
  a_search_flag: assert property (p_search_flag) else $error("search flag wrong"); // [RULE_21]

  property p_search_index;
    @(posedge core_clk) disable iff (!nrst)
    op_ok && op_code == tlbcm_pkg::OP_SEARCH && hit_any && !miss_event
      |=> entry_select == $past(hit_idx) && ent_valid[entry_select];
  endproperty
  a_search_index: assert property (p_search_index) else $error("search hit index wrong"); // [RULE_11]

  property p_protect_kept;
    @(posedge core_clk) disable iff (!nrst)
    op_ok && op_code == tlbcm_pkg::OP_INVAL && ent_valid[0] && ent_invalidation_protect[0] |=> ent_valid[0];
  endproperty
  a_protect_kept: assert property (p_protect_kept) else $error("protected entry invalidated"); // [RULE_20]

  property p_inval_all;
    @(posedge core_clk) disable iff (!nrst)
    op_ok && op_code == tlbcm_pkg::OP_INVAL && eff_addr[3:2] == 2'h3 && !ent_invalidation_protect[1] |=> !ent_valid[1];
  endproperty
  a_inval_all: assert property (p_inval_all) else $error("invalidate-all missed entry"); // [RULE_14]

  property p_write_read;
    logic [31:0] w2;
    @(posedge core_clk) disable iff (!nrst)
    (op_ok && op_code == tlbcm_pkg::OP_WRITE && sel_associativity_field && !miss_event, w2 = asr2) ##0 s_write_then_read
      |=> asr2 == (w2 & 32'hFFFF_FC1F);
  endproperty
  a_write_read: assert property (p_write_read) else $error("entry write not read back"); // [RULE_07]

  property p_miss_load;
    @(posedge core_clk) disable iff (!nrst)
    miss_event |=> asr2[tlbcm_pkg::A2_EPN_LSB +: 22] == $past(miss_ea[31:10])
      && entry_select == $past(asr0[tlbcm_pkg::A0_NV_LSB +: 4]) && asr1[tlbcm_pkg::A1_VALID];
  endproperty
  a_miss_load: assert property (p_miss_load) else $error("miss update wrong"); // [RULE_08]

  property p_ea_form;
    @(posedge core_clk) disable iff (!nrst)
    ra_index == 5'h00 |-> eff_addr == rb_value;
  endproperty
  a_ea_form: assert property (p_ea_form) else $error("address ignores zero index"); // [RULE_10]
endmodule
